// >>> design/ssq_pkg.sv
// Shared constants for the serial converter sequencer
package ssq_pkg;
	localparam int RES_BITS = 8;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CLK_FIRST = 4'h1;
	localparam logic [CNT_W-1:0] CLK_SAMPLE = 4'h3;
	localparam logic [CNT_W-1:0] CLK_LAST_DECIDE = 4'hA;
	localparam logic [CNT_W-1:0] CLK_LAST = 4'hC;
	localparam int FIFO_DEPTH = 8;
	localparam int SYS_CLK_HZ = 25000000;
	localparam int SYS_CLK_NS = 1000000000 / SYS_CLK_HZ;
	localparam logic [RES_BITS-1:0] CODE_ZERO = 8'h00;
	localparam logic SC_IDLE_LEVEL = 1'b1;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONV,
		ST_PUSH
	} ssq_state_t;
endpackage : ssq_pkg

// >>> design/ssq_fifo.sv
// Result word FIFO with valid/ready on both sides
module ssq_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

	assign in_ready = count_q != FULL_COUNT;
	assign out_valid = count_q != '0;
	assign out_data = mem[rd_ptr_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : ssq_fifo

// >>> design/ssq_sequencer.sv
// Conversion sequencer and serial readout of an 8-bit successive-approximation converter
// Notes on behaviour
// - Each conversion takes exactly twelve clocks from the first conversion clock.
// - Start line held low begins a conversion at the third rising clock edge.
// - Output is driven low from conversion start until the first result bit.
// - Clocks one and two track; the input is sampled at the end of clock three.
// - Clocks three to ten resolve eight bits by successive approximation, MSB first.
// - Each bit appears as soon as decided, one per clock, through the LSB.
// - Start line high after the last bit: output floats, block idles until low again.
// - Start low by the end of clock ten: output low, next conversion follows at once.
// - Every bit but the last holds for one full clock period.
// - LSB stays only through clock twelve, as the next conversion may start then.
// - Result is unsigned straight binary: bottom gives zeros, full scale all ones.
// - Input is tracked until sampled at clock three; later changes have no effect.
// - In free-running operation the output stays driven low between conversions while the FIFO has room.
// - A full FIFO at clock twelve holds it driven low until room, then floats it for at least a clock via idle.
module ssq_sequencer
	import ssq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start_convert_n,
	input wire logic [RES_BITS-1:0] analog_code,
	output logic serial_data,
	output logic serial_data_oe,
	output logic result_valid,
	input wire logic result_ready,
	output logic [RES_BITS-1:0] result_data
);
	ssq_state_t state_q, state_d;
	logic sc_meta_q, sc_sync_q;
	logic [RES_BITS-1:0] ain_meta_q, ain_sync_q;
	logic [RES_BITS-1:0] sample_q, sample_d;
	logic [RES_BITS-1:0] sar_q, sar_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic dout_q, dout_d;
	logic oe_q, oe_d;
	logic armed_q;
	logic fifo_ready;

	// Bit position decided in a given conversion clock
	function automatic logic [2:0] bit_index(input logic [CNT_W-1:0] c);
		bit_index = 3'(CLK_LAST_DECIDE - c);
	endfunction : bit_index

	wire sc_low = !sc_sync_q;
	wire at_sample = (state_q == ST_CONV) && (cnt_q == CLK_SAMPLE);
	wire deciding = (state_q == ST_CONV) && (cnt_q >= CLK_SAMPLE) && (cnt_q <= CLK_LAST_DECIDE);
	wire at_last = (state_q == ST_CONV) && (cnt_q == CLK_LAST);
	// Live input in the sample clock, held sample otherwise
	wire [RES_BITS-1:0] cmp_src = at_sample ? ain_sync_q : sample_q;
	wire [RES_BITS-1:0] trial = sar_q | (RES_BITS'(1) << bit_index(cnt_q));
	wire bit_dec = trial <= cmp_src;
	// Start only with room for the result; a full FIFO holds the block idle
	wire start_ok = armed_q && sc_low && fifo_ready;
	wire push_valid = at_last || (state_q == ST_PUSH);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sample_d = sample_q;
		sar_d = sar_q;
		dout_d = dout_q;
		oe_d = oe_q;
		case (state_q)
			ST_IDLE: begin
				oe_d = 1'b0;
				if (start_ok) begin
					state_d = ST_CONV;
					cnt_d = CLK_FIRST;
					sar_d = CODE_ZERO;
					dout_d = 1'b0;
					oe_d = 1'b1;
				end
			end
			ST_CONV: begin
				cnt_d = cnt_q + 1'b1;
				if (at_sample) begin
					sample_d = ain_sync_q;
				end
				if (deciding) begin
					sar_d = bit_dec ? trial : sar_q;
					dout_d = bit_dec;
				end
				if (at_last) begin
					// LSB leaves here, so it stands only through clock twelve
					if (!fifo_ready) begin
						state_d = ST_PUSH;
						dout_d = 1'b0;
					end else if (sc_low) begin
						cnt_d = CLK_FIRST;
						sar_d = CODE_ZERO;
						dout_d = 1'b0;
					end else begin
						state_d = ST_IDLE;
						dout_d = 1'b0;
						oe_d = 1'b0;
					end
				end
			end
			ST_PUSH: begin
				if (fifo_ready) begin
					state_d = ST_IDLE;
					oe_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				oe_d = 1'b0;
			end
		endcase
	end

	// Start line resets away from idle, so only a real high on the pin can arm
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sc_meta_q <= ~SC_IDLE_LEVEL;
			sc_sync_q <= ~SC_IDLE_LEVEL;
			ain_meta_q <= CODE_ZERO;
			ain_sync_q <= CODE_ZERO;
		end else begin
			sc_meta_q <= start_convert_n;
			sc_sync_q <= sc_meta_q;
			ain_meta_q <= analog_code;
			ain_sync_q <= ain_meta_q;
		end
	end

	// Armed once the start line is seen high, so a line stuck low at reset starts nothing
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (sc_sync_q) begin
			armed_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			sample_q <= CODE_ZERO;
			sar_q <= CODE_ZERO;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sample_q <= sample_d;
			sar_q <= sar_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
		end
	end

	assign serial_data = dout_q;
	assign serial_data_oe = oe_q;

	ssq_fifo #(
		.WIDTH(RES_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst(rst),
		.in_valid(push_valid),
		.in_ready(fifo_ready),
		.in_data(sar_q),
		.out_valid(result_valid),
		.out_ready(result_ready),
		.out_data(result_data)
	);
endmodule : ssq_sequencer

// >>> verification/ssq_checker.sv
// Port-level property checker for the converter sequencer
module ssq_checker
	import ssq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start_convert_n,
	input wire logic serial_data,
	input wire logic serial_data_oe,
	input wire logic result_valid,
	input wire logic result_ready,
	input wire logic [RES_BITS-1:0] result_data
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	// Clock index within a conversion, minus one
	assign cnt_d = (!serial_data_oe || cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_quiet_head: assert property (serial_data_oe && cnt_q < 4'h3 |-> !serial_data)
		else $error("output not low before first bit");
	a_conv_span: assert property ($fell(serial_data_oe) && !$past(result_ready)
		&& !$past(result_ready, 2) |-> $past(cnt_q) == 4'hB) else $error("bad length");
	a_lsb_hold: assert property (serial_data_oe && cnt_q == 4'hB |-> $stable(serial_data))
		else $error("lsb not held");
	a_start_delay: assert property ($rose(serial_data_oe) |-> !$past(start_convert_n, 3))
		else $error("start without low line");
	a_stay_idle: assert property (!serial_data_oe && start_convert_n && $past(start_convert_n)
		&& $past(start_convert_n, 2) |=> !serial_data_oe)
		else $error("started while line high");
	a_reset_float: assert property ($fell(rst) |-> !serial_data_oe && !result_valid)
		else $error("not idle after reset");
	a_back_to_back: assert property (serial_data_oe && cnt_q == 4'hB
		&& !$past(start_convert_n, 2) |=> serial_data_oe && !serial_data) else $error("no rerun");
	a_word_hold: assert property (result_valid && !result_ready
		|=> result_valid && $stable(result_data)) else $error("word lost");
endmodule : ssq_checker

bind ssq_sequencer ssq_checker ssq_checker_i (.sys_clk, .rst, .start_convert_n, .serial_data,
	.serial_data_oe, .result_valid, .result_ready, .result_data);

// >>> verification/ssq_host.sv
// Host serial receiver that latches each result word
module ssq_host (
	input wire logic sys_clk,
	input wire logic oe,
	input wire logic sd,
	output logic [7:0] word,
	output int n
);
	timeunit 1ns;
	timeprecision 1ns;
	int c = 0;
	initial word = 8'h00;
	initial n = 0;
	always @(posedge sys_clk) begin
		c = oe ? c + 1 : 0;
		if (c > 3 && c < 12) word = {word[6:0], sd};
		if (c == 12) begin
			n++;
			c = 0;
		end
	end
endmodule : ssq_host

// >>> verification/tb_top.sv
// Self-checking bench for the converter sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic sc_n = 1'b1;
	logic rdy = 1'b0;
	logic oe, sd, rv;
	logic [7:0] code = 8'h00;
	logic [7:0] rd, word;
	logic [7:0] rows [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
	int n, w, miscompares = 0, checked = 0;
	always #20 sys_clk = ~sys_clk;
	ssq_sequencer ssq_sequencer_i (.sys_clk, .rst, .start_convert_n(sc_n), .analog_code(code),
		.serial_data(sd), .serial_data_oe(oe), .result_valid(rv), .result_ready(rdy),
		.result_data(rd));
	ssq_host ssq_host_i (.sys_clk, .oe, .sd, .word, .n);
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	task automatic waitn(input int k);
		k += n;
		w = 0;
		while (n < k) begin
			@(negedge sys_clk);
			if (++w > 2000) begin
				miscompares++;
				results();
			end
		end
	endtask : waitn
	initial begin
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk({7'h00, oe}, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			code = rows[i];
			sc_n = 1'b0;
			@(negedge sys_clk);
			sc_n = 1'b1;
			repeat (5) @(negedge sys_clk);
			code = ~rows[i];
			waitn(1);
			chk(word, rows[i]);
			@(negedge sys_clk);
			chk({6'h00, rv, oe}, 8'h02);
			chk(rd, rows[i]);
			rdy = 1'b1;
			@(negedge sys_clk);
			rdy = 1'b0;
			chk({7'h00, rv}, 8'h00);
			$display("row %0d done", i);
		end
		code = 8'h3C;
		sc_n = 1'b0;
		waitn(3);
		chk(word, 8'h3C);
		repeat (120) @(negedge sys_clk);
		chk({7'h00, rv}, 8'h01);
		sc_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		rdy = 1'b1;
		w = 0;
		while (rv === 1'b1 && w < 20) begin
			chk(rd, 8'h3C);
			w++;
			@(negedge sys_clk);
		end
		chk({7'h00, w >= 8}, 8'h01);
		chk({7'h00, rv}, 8'h00);
		$display("free run test done");
		rst = 1'b1;
		sc_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		repeat (20) @(negedge sys_clk);
		chk({6'h00, rv, oe}, 8'h00);
		sc_n = 1'b1;
		code = 8'h81;
		repeat (3) @(negedge sys_clk);
		sc_n = 1'b0;
		@(negedge sys_clk);
		sc_n = 1'b1;
		waitn(1);
		chk(word, 8'h81);
		$display("reset with start low test done");
		results();
	end
endmodule : tb_top
